// ===== design/aesh_defines.vh
// constants for the serial converter host controller
`ifndef AESH_DEFINES_VH
`define AESH_DEFINES_VH
`define AESH_WORD_BITS 24
`define AESH_BYTE_BITS 8
`define AESH_BYTES_MAX 3
`define AESH_CLK_DIV 4
`define AESH_CMD_DATA 2'h0
`define AESH_CMD_CTRL_RD 2'h1
`define AESH_CMD_CAL_RD 2'h2
`define AESH_CMD_WRITE 2'h3
`endif

// ===== design/aesh_sync.v
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module aesh_sync #(
    parameter WIDTH = 1
) (
    // clock and reset
    input wire ref_clk_i,
    input wire resetn_i,
    // pins in, synchronised out
    input wire [WIDTH-1:0] async_i,
    input wire [WIDTH-1:0] rst_val_i,
    output wire [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] meta_q; // first stage, read only by second stage
    reg [WIDTH-1:0] sync_q; // second stage
    genvar gi;
    // per bit, though every bit resets to 1 and rst_val_i is not used
    generate
        for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
            always @(posedge ref_clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    meta_q[gi] <= 1'b1; // idle high lines
                    sync_q[gi] <= 1'b1;
                end else begin
                    meta_q[gi] <= async_i[gi];
                    sync_q[gi] <= meta_q[gi];
                end
            end
        end
    endgenerate
    assign sync_o = sync_q;
endmodule // aesh_sync

// ===== design/aesh_host.v
// host controller driving the converter serial port in external clocking mode
`timescale 1ns/100ps
`include "aesh_defines.vh"
module aesh_host #(
    parameter CLK_DIV = `AESH_CLK_DIV,      // half period of serial clock in ref cycles
    parameter TIED_WIRING = 0,              // 1: write frame is wired to register select
    parameter RX_BYTES = `AESH_BYTES_MAX    // bytes per data read (2 gives 16-bit words)
) (
    // clock and reset
    input wire ref_clk_i,
    input wire resetn_i,
    // user command
    input wire cmd_valid_i,
    input wire [1:0] cmd_op_i,
    input wire [23:0] cmd_wdata_i,
    input wire lsb_first_i,
    output wire cmd_ready_o,
    // user answer
    output reg rsp_valid_o,
    output reg [23:0] rsp_rdata_o,
    output wire busy_o,
    output wire data_avail_o,
    // converter pins
    output reg serial_clk_o,
    output reg read_frame_n_o,
    output reg write_frame_n_o,
    output reg register_select_o,
    input wire data_ready_n_i,
    input wire serial_data_line_i,
    output reg serial_data_line_o,
    output reg serial_data_line_oe_n_o
);
    // how a command runs:
    // - idle: serial clock low, both strobes and select high, data line released
    // - setup: the strobe drops, with select low for writes and, without tied wiring, control reads; a data read first waits for ready
    // - low and high: each serial clock phase lasts CLK_DIV reference cycles
    // - the converter moves its bit on our falling edge and we take it at the end of
    //   the next high phase, so the two-flop delay on the data pin fits in one phase
    // - gap: strobes, select and the data line go back to idle
    // - done: one-cycle answer pulse with the assembled word
    // limitation: CLK_DIV below 2 leaves no room for the synchroniser delay
    // limitation: writes always address control, so calibration cannot be written
    // trade-off: one gap cycle costs little and keeps select valid past the last bit

    // sequencer states
    localparam ST_IDLE = 3'h0;
    localparam ST_SETUP = 3'h1;
    localparam ST_LOW = 3'h2;
    localparam ST_HIGH = 3'h3;
    localparam ST_GAP = 3'h4;
    localparam ST_DONE = 3'h5;
    // counts derived from parameters, cut to the widths of their registers
    localparam [7:0] DIV_LAST = CLK_DIV - 1;
    localparam [4:0] RX_LAST = RX_BYTES * `AESH_BYTE_BITS - 1;
    localparam [4:0] W_LAST = `AESH_WORD_BITS - 1;

    // synchronised pins
    wire [1:0] pins_sync; // synchronised ready and serial data
    wire ready_n_s;
    wire serial_data_line_s;
    // sequencer and shift state
    reg [2:0] state_q;
    reg [7:0] div_q;       // serial clock phase timer
    reg [4:0] bit_q;       // bits moved in this word
    reg [4:0] last_q;      // index of the final bit
    reg [23:0] sh_q;       // shift register, msb goes first
    reg is_wr_q;
    reg is_data_q;
    reg is_ctrl_q;         // control read: the only read that wants select low
    reg lsb_q;
    wire [23:0] rev_bytes;

    // ready and data come from outside, two flops before any logic reads them
    aesh_sync #(.WIDTH(2)) u_sync (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .async_i({data_ready_n_i, serial_data_line_i}),
        .rst_val_i(2'h3),
        .sync_o(pins_sync)
    );
    assign ready_n_s = pins_sync[1];
    assign serial_data_line_s = pins_sync[0];

    // per byte reversal for lsb-first users, each byte on its own
    // works on the captured word, so it serves writes in setup and reads in done
    genvar gb;
    genvar gk;
    generate
        for (gb = 0; gb < 3; gb = gb + 1) begin : g_byte
            for (gk = 0; gk < 8; gk = gk + 1) begin : g_bit
                assign rev_bytes[gb*8+gk] = (lsb_q ? sh_q[gb*8+7-gk] : sh_q[gb*8+gk]);
            end
        end
    endgenerate

    // ready and busy are combinational from the state, data_avail_o from the synchronised ready pin
    assign cmd_ready_o = (state_q == ST_IDLE);
    assign busy_o = (state_q != ST_IDLE);
    assign data_avail_o = ~ready_n_s; // level usable as a polled flag or edge source

    // main sequencer: setup, then 24 (or 16) clock periods, then idle lines
    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            // sequencer idle, shift state cleared
            state_q <= ST_IDLE;
            div_q <= 8'h00;
            bit_q <= 5'h00;
            last_q <= 5'h00;
            sh_q <= 24'h000000;
            is_wr_q <= 1'b0;
            is_data_q <= 1'b0;
            is_ctrl_q <= 1'b0;
            lsb_q <= 1'b0;
            rsp_valid_o <= 1'b0;
            rsp_rdata_o <= 24'h000000;
            // strobes and select idle high, data line released
            serial_clk_o <= 1'b0;
            read_frame_n_o <= 1'b1;
            write_frame_n_o <= 1'b1;
            register_select_o <= 1'b1;
            serial_data_line_o <= 1'b0;
            serial_data_line_oe_n_o <= 1'b1;
        end else begin
            rsp_valid_o <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    // the only state that takes a command, one at a time
                    serial_clk_o <= 1'b0; // clock low between operations
                    lsb_q <= lsb_first_i;
                    if (cmd_valid_i) begin
                        is_wr_q <= (cmd_op_i == `AESH_CMD_WRITE);
                        is_data_q <= (cmd_op_i == `AESH_CMD_DATA);
                        is_ctrl_q <= (cmd_op_i == `AESH_CMD_CTRL_RD);
                        // data reads may be 16 bits, register access always 24
                        last_q <= (cmd_op_i == `AESH_CMD_DATA) ? RX_LAST : W_LAST;
                        sh_q <= cmd_wdata_i;
                        div_q <= 8'h00;
                        bit_q <= 5'h00;
                        state_q <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    // wait for ready only on data reads; register reads ignore it
                    if (!is_data_q || !ready_n_s) begin
                        if (is_wr_q) begin
                            // write path: first bit is on the line before the first rising clock
                            sh_q <= rev_bytes;
                            // select low with the write frame, as tied wiring forces anyway
                            register_select_o <= 1'b0;
                            write_frame_n_o <= 1'b0;
                            serial_data_line_oe_n_o <= 1'b0;
                            serial_data_line_o <= rev_bytes[23]; // msb first
                        end else if (is_ctrl_q && (TIED_WIRING == 0)) begin
                            // control read drops select together with the read frame
                            register_select_o <= 1'b0;
                            read_frame_n_o <= 1'b0; // read frame is the primary strobe
                        end else begin
                            // data and calibration sit behind select high; with tied wiring a
                            // control read lands here too, so control is never read
                            register_select_o <= 1'b1;
                            read_frame_n_o <= 1'b0;
                        end
                        state_q <= ST_LOW;
                    end else begin
                        // ready still high on a data read: the frame stays shut
                        state_q <= ST_SETUP;
                    end
                end
                ST_LOW: begin
                    // serial clock low phase
                    // device moves its bit on our falling edge; sample at the end of the following high phase
                    if (div_q == DIV_LAST) begin
                        div_q <= 8'h00;
                        serial_clk_o <= 1'b1;
                        state_q <= ST_HIGH;
                    end else begin
                        div_q <= div_q + 8'h01;
                    end
                end
                ST_HIGH: begin
                    // serial clock high phase; the converter takes our write bit here
                    if (div_q == DIV_LAST) begin
                        div_q <= 8'h00;
                        serial_clk_o <= 1'b0;
                        // shift in msb-first, two-stage sync delay covered by the half period
                        sh_q <= {sh_q[22:0], is_wr_q ? 1'b0 : serial_data_line_s};
                        // next write bit leaves on our falling edge, stable through the high phase
                        serial_data_line_o <= sh_q[22];
                        bit_q <= bit_q + 5'h01;
                        // last falling edge lets ready rise on data reads
                        state_q <= (bit_q == last_q) ? ST_GAP : ST_LOW;
                    end else begin
                        div_q <= div_q + 8'h01;
                    end
                end
                ST_GAP: begin
                    // release lines to idle high levels
                    read_frame_n_o <= 1'b1;
                    write_frame_n_o <= 1'b1;
                    register_select_o <= 1'b1;
                    // data line released so the converter may drive it on the next read
                    serial_data_line_oe_n_o <= 1'b1;
                    state_q <= ST_DONE;
                end
                ST_DONE: begin
                    // byte-wise assembly of the word as two or three bytes
                    rsp_valid_o <= 1'b1;
                    // lsb-first users get every byte mirrored, as on writes
                    if (is_data_q && (RX_BYTES == 2)) begin
                        // 16-bit words are zero-extended
                        rsp_rdata_o <= {8'h00, rev_bytes[15:0]};
                    end else begin
                        rsp_rdata_o <= rev_bytes;
                    end
                    state_q <= ST_IDLE;
                end
                // recover from an illegal state code
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // aesh_host

// ===== verif/aesh_host_props.sv
// assertions on the pins of the serial converter host controller
`timescale 1ns/100ps
module aesh_host_props #(parameter CLK_DIV = 4, parameter RX_BYTES = 3) (
    // watched ports
    input wire ref_clk_i, resetn_i, cmd_valid_i, cmd_ready_o, rsp_valid_o, busy_o, data_avail_o,
    input wire [1:0] cmd_op_i,
    input wire serial_clk_o, read_frame_n_o, write_frame_n_o, register_select_o,
    input wire serial_data_line_o, serial_data_line_oe_n_o
);
    reg [1:0] op_q; // operation in flight
    reg [5:0] cnt_q; // serial clock rises in the open frame
    reg sck_q; // last serial clock level
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    // count clock rises while a frame is open, clear once both frames idle
    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            op_q <= 2'h0;
            cnt_q <= 6'h00;
            sck_q <= 1'b0;
        end else begin
            if (cmd_valid_i && cmd_ready_o) op_q <= cmd_op_i;
            sck_q <= serial_clk_o;
            if (read_frame_n_o && write_frame_n_o) cnt_q <= 6'h00;
            else if (serial_clk_o && !sck_q) cnt_q <= cnt_q + 6'h01;
        end
    end
    ready_gate_a: assert property ($fell(read_frame_n_o) && op_q == 2'h0 |-> data_avail_o)
        else $error("data read opened without ready");
    ctrl_select_a: assert property ($fell(read_frame_n_o) && op_q == 2'h1 |-> !register_select_o)
        else $error("control read opened without select low");
    frame_bits_a: assert property ($rose(read_frame_n_o) || $rose(write_frame_n_o) |->
        cnt_q == (op_q == 2'h0 ? 8 * RX_BYTES : 24)) else $error("wrong bit count in frame");
    idle_lines_a: assert property (rsp_valid_o |-> read_frame_n_o && write_frame_n_o && register_select_o)
        else $error("lines not idle at answer");
    one_frame_a: assert property (read_frame_n_o || write_frame_n_o)
        else $error("both frames low");
    clk_idle_a: assert property (read_frame_n_o && write_frame_n_o |-> !serial_clk_o)
        else $error("serial clock high outside frames");
    data_hold_a: assert property (!write_frame_n_o && serial_clk_o |-> $stable(serial_data_line_o))
        else $error("write data moved in clock high");
    drive_dir_a: assert property (!read_frame_n_o |-> serial_data_line_oe_n_o)
        else $error("host drives data during read");
    cover property ($rose(rsp_valid_o) && op_q == 2'h0);
    cover property ($rose(rsp_valid_o) && op_q == 2'h1);
    cover property ($rose(rsp_valid_o) && op_q == 2'h3);
endmodule // aesh_host_props
bind aesh_host aesh_host_props #(.CLK_DIV(CLK_DIV), .RX_BYTES(RX_BYTES)) aesh_host_props_i (.*);

// ===== verif/aesh_dev_model.sv
// behavioural model of the converter serial port
`timescale 1ns/100ps
module aesh_dev_model (
    // serial port pins
    input wire serial_clk_i,
    input wire read_frame_n_i,
    input wire write_frame_n_i,
    input wire register_select_i,
    input wire sdi_i,
    output reg sdo_o,
    output reg data_ready_n_o
);
    reg [23:0] ctrl_q = 24'h000000; // control register
    reg [23:0] cal_q = 24'h3C5A0F; // calibration word, arbitrary start
    reg [23:0] out_q = 24'h000000; // output data register
    reg [23:0] sh_q = 24'h000000; // word being sent
    reg [23:0] wr_q = 24'h000000; // word being received
    reg cal_sel = 1'b0; // select high reads calibration instead of data
    integer n_rd = 0; // bits sent, kept across split frames
    integer n_wr = 0; // bits received
    initial data_ready_n_o = 1'b1;
    initial sdo_o = 1'b0;
    // a fresh conversion result
    task new_word(input [23:0] w);
        out_q = w;
        data_ready_n_o = 1'b0;
    endtask
    // frame opens: choose source on a fresh word, current bit (msb on a fresh word) out at once
    always @(negedge read_frame_n_i) begin
        if (n_rd == 0) sh_q = !register_select_i ? ctrl_q : (cal_sel ? cal_q : out_q);
        sdo_o = sh_q[23 - n_rd];
    end
    // next bit on each falling clock edge; ready rises after the last one on data reads
    always @(negedge serial_clk_i) begin
        if (!read_frame_n_i) begin
            n_rd = (n_rd + 1) % 24;
            if (n_rd == 0 && register_select_i && !cal_sel) data_ready_n_o = 1'b1;
            sdo_o = sh_q[23 - n_rd];
        end
    end
    // released line shows no stale bit
    always @(posedge read_frame_n_i) sdo_o = ~sdo_o;
    // bits taken at clock rise, first is msb, 24 to a word
    always @(posedge serial_clk_i) begin
        if (!write_frame_n_i) begin
            wr_q = {wr_q[22:0], sdi_i};
            n_wr = (n_wr + 1) % 24;
            if (n_wr == 0 && !register_select_i) ctrl_q = wr_q;
            else if (n_wr == 0) cal_q = wr_q;
        end
    end
endmodule // aesh_dev_model

// ===== verif/tb_aesh_host.sv
// self-checking bench for the serial converter host controller
`timescale 1ns/100ps
module tb_aesh_host;
    reg ref_clk_i = 1'b0, resetn_i = 1'b0, cmd_valid_i = 1'b0, lsb_first_i = 1'b0;
    reg [1:0] cmd_op_i = 2'h0;
    reg [23:0] cmd_wdata_i = 24'h000000;
    wire cmd_ready_o, rsp_valid_o, busy_o, data_avail_o, serial_clk_o, read_frame_n_o, write_frame_n_o;
    wire register_select_o, serial_data_line_o, serial_data_line_oe_n_o, data_ready_n_i, sdo;
    wire [23:0] rsp_rdata_o;
    wire serial_data_line_i = !serial_data_line_oe_n_o ? serial_data_line_o : sdo; // shared line
    reg [1:0] op_t [0:5];
    reg [23:0] wd_t [0:5], ex_t [0:5];
    reg lsb_t [0:5];
    integer n_errors = 0, comparisons = 0, cycles = 0, i;
    aesh_host aesh_host_i (.*);
    aesh_dev_model aesh_dev_model_i (.serial_clk_i(serial_clk_o), .read_frame_n_i(read_frame_n_o),
        .write_frame_n_i(write_frame_n_o), .register_select_i(register_select_o),
        .sdi_i(serial_data_line_i), .sdo_o(sdo), .data_ready_n_o(data_ready_n_i));
    initial forever #25 ref_clk_i = ~ref_clk_i;
    task check(input [23:0] seen, input [23:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task issue(input [1:0] op, input [23:0] wd, input lsb);
        @(negedge ref_clk_i);
        cmd_valid_i = 1'b1;
        cmd_op_i = op;
        cmd_wdata_i = wd;
        lsb_first_i = lsb;
        @(negedge ref_clk_i);
        cmd_valid_i = 1'b0;
    endtask
    task wait_rsp;
        for (i = 0; i < 2000 && rsp_valid_o !== 1'b1; i = i + 1) @(negedge ref_clk_i);
        check({23'h000000, rsp_valid_o}, 24'h000001);
    endtask
    task print_verdict;
        if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // hang guard, far above the few thousand cycles the run needs
    always @(posedge ref_clk_i) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            print_verdict;
        end
    end
    initial begin : main
        integer r;
        // rows: write, read back, reversed write, reversed read back, data, calibration
        op_t = '{2'h3, 2'h1, 2'h3, 2'h1, 2'h0, 2'h2};
        wd_t = '{24'hA5C3E1, 24'h000000, 24'h010280, 24'h000000, 24'h123456, 24'h000000};
        ex_t = '{24'hA5C3E1, 24'hA5C3E1, 24'h804001, 24'h010280, 24'h123456, 24'h3C5A0F};
        lsb_t = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
        repeat (6) @(negedge ref_clk_i);
        resetn_i = 1'b1;
        for (r = 0; r < 6; r = r + 1) begin
            if (op_t[r] == 2'h0) aesh_dev_model_i.new_word(wd_t[r]);
            aesh_dev_model_i.cal_sel = (op_t[r] == 2'h2);
            issue(op_t[r], wd_t[r], lsb_t[r]);
            wait_rsp;
            check(op_t[r] == 2'h3 ? aesh_dev_model_i.ctrl_q : rsp_rdata_o, ex_t[r]);
        end
        // data read held off until ready falls, then one 24-bit word
        aesh_dev_model_i.cal_sel = 1'b0;
        issue(2'h0, 24'h000000, 1'b0);
        repeat (60) @(negedge ref_clk_i);
        check({busy_o, read_frame_n_o, data_avail_o}, 24'h000006);
        aesh_dev_model_i.new_word(24'hABCDEF);
        wait_rsp;
        check(rsp_rdata_o, 24'hABCDEF);
        // control read ignores a pending ready, which stays low
        aesh_dev_model_i.new_word(24'h111111);
        issue(2'h1, 24'h000000, 1'b0);
        wait_rsp;
        check(rsp_rdata_o, 24'h804001);
        check({23'h000000, data_ready_n_i}, 24'h000000);
        // reset in mid-write returns every line to idle
        issue(2'h3, 24'hFFFFFF, 1'b0);
        repeat (30) @(negedge ref_clk_i);
        resetn_i = 1'b0;
        #1 check({read_frame_n_o, write_frame_n_o, register_select_o, serial_clk_o, serial_data_line_oe_n_o}, 24'h1D);
        // release again: idle at once, and the cut write never reached control
        repeat (2) @(negedge ref_clk_i);
        resetn_i = 1'b1;
        repeat (2) @(negedge ref_clk_i);
        check({busy_o, rsp_valid_o, read_frame_n_o, write_frame_n_o, serial_clk_o}, 24'h000006);
        issue(2'h1, 24'h000000, 1'b0);
        wait_rsp;
        check(rsp_rdata_o, 24'h804001);
        print_verdict;
    end
endmodule // tb_aesh_host
